// ==== hdl/acd_aux_command_decoder.sv ====
// auxiliary command port: byte decode, commands and interface flags
`timescale 1ns/1ps

// Functional notes
// - write-only byte port at offset B
// - bits 7-5 selector, bits 4-0 command
// - selector zero executes the named command
// - nonzero selector executes nothing; 2 and 6 load no register
// - five hidden registers, written only here
// - codes 00,02-06 pon, reset, finish, trigger, rtl, eoi
// - 07 marks secondary invalid, 0F valid
// - 01 clears poll flag, 09 sets
// - take control: 11 async, 12 sync, 1A end
// - 13 listen, 1B continuous, 1C unlisten
// - 10 standby, 14 no sysctl, 1D poll
// - 1E/16 interface clear, 1F/17 remote enable
// - secondary capture holds acceptor until verdict
// - chip reset clears poll flag and sysctl, returns hidden regs bar poll response to reset values, holds idle
// - finish handshake releases data holdoff
module acd_aux_command_decoder (
  input wire logic clk_sys, // 50 MHz system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [3:0] hostAddr, // byte offset from board base
  input wire logic [7:0] hostData, // write data byte
  input wire logic hostWrEn, // write strobe, one cycle per byte
  input wire logic sysCtrlSet, // core grants system controller
  input wire logic secCaptured, // core captured secondary or unknown
  input wire logic holdoffSeen, // core stopped handshake on holdoff
  output logic ponActive, // local power-on, functions idle
  output logic ponPulse, // immediate power-on executed while running
  output logic chipResetPulse, // chip reset executed
  output logic finishHandshake, // finish handshake pulse
  output logic triggerPulse, // trigger pulse
  output logic returnLocal, // return to local pulse
  output logic sendEoi, // send end-or-identify pulse
  output logic secValid, // secondary valid pulse
  output logic secInvalid, // secondary invalid pulse
  output logic takeCtrlAsync, // take control asynchronously
  output logic takeCtrlSync, // take control synchronously
  output logic takeCtrlSyncEnd, // take control on end
  output logic goStandby, // go to standby pulse
  output logic listenCmd, // listen pulse
  output logic listenCont, // listen continuous pulse
  output logic localUnlisten, // local unlisten pulse
  output logic execParPoll, // execute parallel poll pulse
  output logic disableSysCtrl, // disable system control pulse
  output logic parPollFlag, // parallel poll flag level
  output logic ifcAssert, // interface clear level
  output logic renAssert, // remote enable level
  output logic sysCtrlEn, // system controller bit
  output logic acceptorHold, // acceptor handshake held
  output logic handshakeHeld, // source/acceptor holdoff pending
  output logic cmdAccepted, // any listed command executed
  output logic hiddenLoad, // a nonzero-selector byte was written
  output logic [4:0] auxConfigA, // aux config register a
  output logic [4:0] auxConfigB, // aux config register b
  output logic [4:0] parPollResp, // parallel poll response
  output logic [4:0] auxConfigE, // aux config register e
  output logic [3:0] clockDividerCount // clock divider count
);

  // ---------------------------------------------------------------
  // port decode and byte split
  // ---------------------------------------------------------------
  // only writes reach this port; reads at the offset are not ours
  wire logic portHit = hostWrEn &&
    (hostAddr == acd_pkg::ACD_PORT_OFFSET);
  wire logic [2:0] controlSelector =
    hostData[acd_pkg::ACD_SEL_MSB:acd_pkg::ACD_SEL_LSB];
  wire logic [4:0] cmdField =
    hostData[acd_pkg::ACD_CMD_MSB:acd_pkg::ACD_CMD_LSB];
  wire logic isCommand =
    (controlSelector == acd_pkg::ACD_SEL_COMMAND);
  wire logic cmdStrobe = portHit && isCommand;
  wire logic loadStrobe = portHit && !isCommand;

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  logic [acd_pkg::ACD_NUM_CMDS-1:0] cmdHit;
  logic cmdKnown;

  acd_cmd_decode uDecode (
    .cmdStrobe(cmdStrobe),
    .cmdCode(cmdField),
    .cmdHit(cmdHit),
    .cmdKnown(cmdKnown)
  );

  // named strobes for the commands that change local state
  wire logic hitPon = cmdHit[acd_pkg::ACD_I_PON];
  wire logic hitChipRst = cmdHit[acd_pkg::ACD_I_CHIPRST];
  wire logic hitFinish = cmdHit[acd_pkg::ACD_I_FINISH];
  wire logic hitValid = cmdHit[acd_pkg::ACD_I_VALID];
  wire logic hitNonValid = cmdHit[acd_pkg::ACD_I_NONVALID];
  wire logic hitPpClr = cmdHit[acd_pkg::ACD_I_PPCLR];
  wire logic hitPpSet = cmdHit[acd_pkg::ACD_I_PPSET];
  wire logic hitIfcSet = cmdHit[acd_pkg::ACD_I_IFCSET];
  wire logic hitIfcClr = cmdHit[acd_pkg::ACD_I_IFCCLR];
  wire logic hitRenSet = cmdHit[acd_pkg::ACD_I_RENSET];
  wire logic hitRenClr = cmdHit[acd_pkg::ACD_I_RENCLR];
  wire logic hitDisSc = cmdHit[acd_pkg::ACD_I_DISSC];
  wire logic secVerdict = hitValid || hitNonValid;

  // ---------------------------------------------------------------
  // hidden registers
  // ---------------------------------------------------------------
  acd_hidden_regs uHidden (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .loadStrobe(loadStrobe),
    .loadSel(controlSelector),
    .loadData(cmdField),
    .chipReset(hitChipRst),
    .auxConfigA(auxConfigA),
    .auxConfigB(auxConfigB),
    .parPollResp(parPollResp),
    .auxConfigE(auxConfigE),
    .clockDividerCount(clockDividerCount)
  );

  // ---------------------------------------------------------------
  // power-on hold state machine
  // ---------------------------------------------------------------
  acd_pkg::acd_state_t stateReg;
  acd_pkg::acd_state_t stateNext;
  logic ponPulseNext;

  // pin reset and chip reset both enter the held state; the power-on
  // command releases it, and only pulses local pon when already running
  always_comb begin
    stateNext = stateReg;
    ponPulseNext = 1'b0;
    case (stateReg)
      acd_pkg::ACD_ST_HELD: begin
        if (hitPon) begin
          stateNext = acd_pkg::ACD_ST_RUN;
        end
      end
      acd_pkg::ACD_ST_RUN: begin
        if (hitChipRst) begin
          stateNext = acd_pkg::ACD_ST_HELD;
        end else if (hitPon) begin
          ponPulseNext = 1'b1;
        end
      end
      default: begin
        stateNext = acd_pkg::ACD_ST_HELD;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stateReg <= acd_pkg::ACD_ST_HELD;
    end else begin
      stateReg <= stateNext;
    end
  end

  // ---------------------------------------------------------------
  // level flags
  // ---------------------------------------------------------------
  logic parPollFlagReg;
  logic parPollFlagNext;
  logic ifcReg;
  logic ifcNext;
  logic renReg;
  logic renNext;
  logic sysCtrlReg;
  logic sysCtrlNext;
  logic acceptorHoldReg;
  logic acceptorHoldNext;
  logic hsHeldReg;
  logic hsHeldNext;

  // chip reset clears poll flag and system controller bit
  assign parPollFlagNext = hitChipRst ? 1'b0 :
    hitPpSet ? 1'b1 : hitPpClr ? 1'b0 : parPollFlagReg;
  assign ifcNext = hitIfcSet ? 1'b1 :
    hitIfcClr ? 1'b0 : ifcReg;
  assign renNext = hitRenSet ? 1'b1 :
    hitRenClr ? 1'b0 : renReg;
  // a grant in the same cycle as a disable loses: disable is explicit
  assign sysCtrlNext = (hitChipRst || hitDisSc) ? 1'b0 :
    sysCtrlSet ? 1'b1 : sysCtrlReg;
  // a new capture beats a verdict arriving in the same cycle
  assign acceptorHoldNext = secCaptured ? 1'b1 :
    secVerdict ? 1'b0 : acceptorHoldReg;
  assign hsHeldNext = holdoffSeen ? 1'b1 :
    hitFinish ? 1'b0 : hsHeldReg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      parPollFlagReg <= 1'b0;
      ifcReg <= 1'b0;
      renReg <= 1'b0;
      sysCtrlReg <= 1'b0;
      acceptorHoldReg <= 1'b0;
      hsHeldReg <= 1'b0;
    end else begin
      parPollFlagReg <= parPollFlagNext;
      ifcReg <= ifcNext;
      renReg <= renNext;
      sysCtrlReg <= sysCtrlNext;
      acceptorHoldReg <= acceptorHoldNext;
      hsHeldReg <= hsHeldNext;
    end
  end

  // ---------------------------------------------------------------
  // command pulses
  // ---------------------------------------------------------------
  // registered so every pulse is exactly one cycle and glitch free;
  // costs one cycle of latency after the write edge
  logic [acd_pkg::ACD_NUM_CMDS-1:0] cmdPulseReg;
  logic ponPulseReg;
  logic cmdAcceptedReg;
  logic hiddenLoadReg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmdPulseReg <= '0;
      ponPulseReg <= 1'b0;
      cmdAcceptedReg <= 1'b0;
      hiddenLoadReg <= 1'b0;
    end else begin
      cmdPulseReg <= cmdHit;
      ponPulseReg <= ponPulseNext;
      cmdAcceptedReg <= cmdKnown;
      hiddenLoadReg <= loadStrobe;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign ponActive = (stateReg == acd_pkg::ACD_ST_HELD);
  assign ponPulse = ponPulseReg;
  assign chipResetPulse = cmdPulseReg[acd_pkg::ACD_I_CHIPRST];
  assign finishHandshake = cmdPulseReg[acd_pkg::ACD_I_FINISH];
  assign triggerPulse = cmdPulseReg[acd_pkg::ACD_I_TRIGGER];
  assign returnLocal = cmdPulseReg[acd_pkg::ACD_I_RTL];
  assign sendEoi = cmdPulseReg[acd_pkg::ACD_I_EOI];
  assign secValid = cmdPulseReg[acd_pkg::ACD_I_VALID];
  assign secInvalid = cmdPulseReg[acd_pkg::ACD_I_NONVALID];
  assign takeCtrlAsync = cmdPulseReg[acd_pkg::ACD_I_TCA];
  assign takeCtrlSync = cmdPulseReg[acd_pkg::ACD_I_TCS];
  assign takeCtrlSyncEnd = cmdPulseReg[acd_pkg::ACD_I_TCSE];
  assign goStandby = cmdPulseReg[acd_pkg::ACD_I_STANDBY];
  assign listenCmd = cmdPulseReg[acd_pkg::ACD_I_LISTEN];
  assign listenCont = cmdPulseReg[acd_pkg::ACD_I_LISTENC];
  assign localUnlisten = cmdPulseReg[acd_pkg::ACD_I_LUNL];
  assign execParPoll = cmdPulseReg[acd_pkg::ACD_I_EXECPP];
  assign disableSysCtrl = cmdPulseReg[acd_pkg::ACD_I_DISSC];
  assign parPollFlag = parPollFlagReg;
  assign ifcAssert = ifcReg;
  assign renAssert = renReg;
  assign sysCtrlEn = sysCtrlReg;
  assign acceptorHold = acceptorHoldReg;
  assign handshakeHeld = hsHeldReg;
  assign cmdAccepted = cmdAcceptedReg;
  assign hiddenLoad = hiddenLoadReg;

endmodule // acd_aux_command_decoder

// ==== hdl/acd_pkg.sv ====
// constants shared by the auxiliary command decoder files
package acd_pkg;

  // ---------------------------------------------------------------
  // host port location and byte layout
  // ---------------------------------------------------------------
  localparam logic [3:0] ACD_PORT_OFFSET = 4'hB; // byte offset from base
  localparam int ACD_SEL_MSB = 7; // control selector field
  localparam int ACD_SEL_LSB = 5;
  localparam int ACD_CMD_MSB = 4; // command / payload field
  localparam int ACD_CMD_LSB = 0;
  localparam logic [2:0] ACD_SEL_COMMAND = 3'h0; // execute, store nothing

  // ---------------------------------------------------------------
  // hidden register selector values
  // ---------------------------------------------------------------
  localparam logic [2:0] ACD_SEL_CLKDIV = 3'h1;
  localparam logic [2:0] ACD_SEL_PPR = 3'h3;
  localparam logic [2:0] ACD_SEL_AUXA = 3'h4;
  localparam logic [2:0] ACD_SEL_AUXB = 3'h5;
  localparam logic [2:0] ACD_SEL_AUXE = 3'h7;

  // ---------------------------------------------------------------
  // reset values of the hidden registers
  // ---------------------------------------------------------------
  localparam logic [4:0] ACD_AUX_RESET = 5'h00;
  localparam logic [4:0] ACD_PPR_RESET = 5'h00;
  localparam logic [3:0] ACD_CLKDIV_RESET = 4'h8;

  // ---------------------------------------------------------------
  // command table: index constants and codes
  // ---------------------------------------------------------------
  localparam int ACD_NUM_CMDS = 23;
  localparam int ACD_I_PON = 0;
  localparam int ACD_I_CHIPRST = 1;
  localparam int ACD_I_FINISH = 2;
  localparam int ACD_I_TRIGGER = 3;
  localparam int ACD_I_RTL = 4;
  localparam int ACD_I_EOI = 5;
  localparam int ACD_I_NONVALID = 6;
  localparam int ACD_I_VALID = 7;
  localparam int ACD_I_PPCLR = 8;
  localparam int ACD_I_PPSET = 9;
  localparam int ACD_I_TCA = 10;
  localparam int ACD_I_TCS = 11;
  localparam int ACD_I_TCSE = 12;
  localparam int ACD_I_STANDBY = 13;
  localparam int ACD_I_LISTEN = 14;
  localparam int ACD_I_LISTENC = 15;
  localparam int ACD_I_LUNL = 16;
  localparam int ACD_I_EXECPP = 17;
  localparam int ACD_I_IFCSET = 18;
  localparam int ACD_I_IFCCLR = 19;
  localparam int ACD_I_RENSET = 20;
  localparam int ACD_I_RENCLR = 21;
  localparam int ACD_I_DISSC = 22;

  // entry i of this table is the code for index i
  localparam logic [ACD_NUM_CMDS-1:0][4:0] ACD_CMD_CODES = {
    5'h14, 5'h17, 5'h1F, 5'h16, 5'h1E, 5'h1D, 5'h1C, 5'h1B,
    5'h13, 5'h10, 5'h1A, 5'h12, 5'h11, 5'h09, 5'h01, 5'h0F,
    5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h00
  };

  // interface function hold state
  typedef enum logic [1:0] {
    ACD_ST_HELD = 2'b01, // local power-on active, functions idle
    ACD_ST_RUN = 2'b10 // released by the immediate power-on command
  } acd_state_t;

endpackage

// ==== hdl/acd_cmd_decode.sv ====
// one-hot decode of the 5-bit auxiliary command code
`timescale 1ns/1ps
module acd_cmd_decode (
  input wire logic cmdStrobe, // command write this cycle
  input wire logic [4:0] cmdCode, // command field of the byte
  output logic [acd_pkg::ACD_NUM_CMDS-1:0] cmdHit, // one bit per command
  output logic cmdKnown // code matched a table entry
);

  // ---------------------------------------------------------------
  // table compare
  // ---------------------------------------------------------------
  // one comparator per entry; unlisted codes leave every bit low
  genvar gi;
  generate
    for (gi = 0; gi < acd_pkg::ACD_NUM_CMDS; gi++) begin : gCmp
      assign cmdHit[gi] = cmdStrobe &&
        (cmdCode == acd_pkg::ACD_CMD_CODES[gi]);
    end
  endgenerate

  assign cmdKnown = |cmdHit;

endmodule // acd_cmd_decode

// ==== hdl/acd_hidden_regs.sv ====
// the five hidden registers loaded through the command port
`timescale 1ns/1ps
module acd_hidden_regs (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic loadStrobe, // hidden register write this cycle
  input wire logic [2:0] loadSel, // control selector of the write
  input wire logic [4:0] loadData, // payload of the write
  input wire logic chipReset, // chip reset command
  output logic [4:0] auxConfigA, // aux config register a
  output logic [4:0] auxConfigB, // aux config register b
  output logic [4:0] parPollResp, // parallel poll response
  output logic [4:0] auxConfigE, // aux config register e
  output logic [3:0] clockDividerCount // clock divider count
);

  // ---------------------------------------------------------------
  // selector decode
  // ---------------------------------------------------------------
  logic [4:0] auxConfigAReg;
  logic [4:0] auxConfigBReg;
  logic [4:0] parPollRespReg;
  logic [4:0] auxConfigEReg;
  logic [3:0] clkDivReg;
  wire logic ldA = loadStrobe && (loadSel == acd_pkg::ACD_SEL_AUXA);
  wire logic ldB = loadStrobe && (loadSel == acd_pkg::ACD_SEL_AUXB);
  wire logic ldP = loadStrobe && (loadSel == acd_pkg::ACD_SEL_PPR);
  wire logic ldE = loadStrobe && (loadSel == acd_pkg::ACD_SEL_AUXE);
  wire logic ldC = loadStrobe && (loadSel == acd_pkg::ACD_SEL_CLKDIV);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  // chip reset matches the pin reset except the poll response, kept
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      auxConfigAReg <= acd_pkg::ACD_AUX_RESET;
      auxConfigBReg <= acd_pkg::ACD_AUX_RESET;
      parPollRespReg <= acd_pkg::ACD_PPR_RESET;
      auxConfigEReg <= acd_pkg::ACD_AUX_RESET;
      clkDivReg <= acd_pkg::ACD_CLKDIV_RESET;
    end else if (chipReset) begin
      auxConfigAReg <= acd_pkg::ACD_AUX_RESET;
      auxConfigBReg <= acd_pkg::ACD_AUX_RESET;
      auxConfigEReg <= acd_pkg::ACD_AUX_RESET;
      clkDivReg <= acd_pkg::ACD_CLKDIV_RESET;
    end else begin
      if (ldA) auxConfigAReg <= loadData;
      if (ldB) auxConfigBReg <= loadData;
      if (ldP) parPollRespReg <= loadData;
      if (ldE) auxConfigEReg <= loadData;
      if (ldC) clkDivReg <= loadData[3:0]; // top payload bit unused
    end
  end

  assign auxConfigA = auxConfigAReg;
  assign auxConfigB = auxConfigBReg;
  assign parPollResp = parPollRespReg;
  assign auxConfigE = auxConfigEReg;
  assign clockDividerCount = clkDivReg;

endmodule // acd_hidden_regs

// ==== test/acd_aux_command_decoder_assertions.sv ====
// concurrent checks on the auxiliary command decoder ports
`timescale 1ns/1ps
module acd_aux_command_decoder_chk (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [3:0] hostAddr, // byte offset
  input wire logic [7:0] hostData, // write byte
  input wire logic hostWrEn, // write strobe
  input wire logic secCaptured, // secondary captured
  input wire logic ponActive, // functions held idle
  input wire logic ponPulse, // power-on pulse
  input wire logic chipResetPulse, // chip reset pulse
  input wire logic triggerPulse, // trigger pulse
  input wire logic parPollFlag, // poll flag level
  input wire logic ifcAssert, // interface clear level
  input wire logic renAssert, // remote enable level
  input wire logic sysCtrlEn, // system controller bit
  input wire logic acceptorHold, // acceptor held
  input wire logic cmdAccepted, // command executed
  input wire logic hiddenLoad, // hidden register written
  input wire logic [4:0] auxConfigA, // aux config a
  input wire logic [3:0] clockDividerCount // clock divider count
);
  // ---------------------------------------------------------------
  // decode of the byte on the bus
  // ---------------------------------------------------------------
  wire logic wrHit = hostWrEn && (hostAddr == 4'hB);
  wire logic selZero = (hostData[7:5] == 3'h0);
  // listed codes; 08 and the other gaps must stay silent
  wire logic listed = hostData[4:0] inside {[5'h00:5'h07], 5'h09,
    5'h0F, [5'h10:5'h14], 5'h16, 5'h17, [5'h1A:5'h1F]};

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // one byte hitting the port with a given value or selector
  sequence s_cmd(logic [7:0] c);
    wrHit && hostData == c;
  endsequence
  sequence s_sel(logic [2:0] s);
    wrHit && hostData[7:5] == s;
  endsequence

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  cmd_accept_a: assert property (cmdAccepted == $past(wrHit && selZero && listed))
    else $error("command pulse without matching write");
  hidden_load_a: assert property (hiddenLoad == $past(wrHit && !selZero))
    else $error("hidden load pulse mismatch");
  trigger_pulse_a: assert property (triggerPulse == $past(wrHit && hostData == 8'h04))
    else $error("trigger pulse mismatch");
  chip_reset_a: assert property (s_cmd(8'h02) |=> chipResetPulse && ponActive &&
    clockDividerCount == 4'h8 && auxConfigA == 5'h00 && !sysCtrlEn && !parPollFlag)
    else $error("chip reset left state behind");
  pon_release_a: assert property (ponActive ##0 s_cmd(8'h00) |=> !ponActive && !ponPulse)
    else $error("power-on did not release held state");
  pon_pulse_a: assert property (!ponActive ##0 s_cmd(8'h00) |=> ponPulse && !ponActive)
    else $error("power-on pulse missing");
  auxa_load_a: assert property (s_sel(3'h4) |=> auxConfigA == $past(hostData[4:0]))
    else $error("aux a payload not loaded");
  clkdiv_load_a: assert property (s_sel(3'h1) |=> clockDividerCount == $past(hostData[3:0]))
    else $error("clock divider payload not loaded");
  acc_hold_a: assert property (secCaptured |=> acceptorHold [*2])
    else $error("acceptor not held after capture");
  acc_release_a: assert property (wrHit && hostData == 8'h0F && !secCaptured |=> !acceptorHold)
    else $error("valid verdict did not release acceptor");
  level_stable_a: assert property (!$past(wrHit) |-> $stable(ifcAssert) && $stable(renAssert))
    else $error("interface clear or remote enable moved alone");
endmodule // acd_aux_command_decoder_chk

bind acd_aux_command_decoder acd_aux_command_decoder_chk chk_u (.clk_sys,
  .rst_n, .hostAddr, .hostData, .hostWrEn, .secCaptured, .ponActive,
  .ponPulse, .chipResetPulse, .triggerPulse, .parPollFlag, .ifcAssert,
  .renAssert, .sysCtrlEn, .acceptorHold, .cmdAccepted, .hiddenLoad,
  .auxConfigA, .clockDividerCount);

// ==== test/acd_host_model.sv ====
// host processor model that writes bytes to the command port
`timescale 1ns/1ps
module acd_host_model (
  input wire logic clk_sys, // system clock
  output logic [3:0] hostAddr, // byte offset driven
  output logic [7:0] hostData, // byte driven
  output logic hostWrEn // write strobe
);
  // ---------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------
  initial begin
    hostAddr = 4'h0;
    hostData = 8'h00;
    hostWrEn = 1'b0;
  end

  // one write; held until the next edge takes it, no reads exist
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #2;
    hostAddr = a;
    hostData = d;
    hostWrEn = 1'b1;
  endtask

  // release: stale bus shows inverted bits so nothing looks valid
  task automatic idle();
    @(posedge clk_sys);
    #2;
    hostWrEn = 1'b0;
    hostAddr = ~hostAddr;
    hostData = ~hostData;
  endtask
endmodule // acd_host_model

// ==== test/tb_aux_command_decoder.sv ====
// self-checking bench for the auxiliary command decoder
`timescale 1ns/1ps
module tb_aux_command_decoder;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic sysCtrlSet = 1'b0;
  logic secCaptured = 1'b0;
  logic holdoffSeen = 1'b0;
  logic [3:0] hostAddr;
  logic [7:0] hostData;
  logic hostWrEn;
  logic ponActive, ponPulse, chipResetPulse, finishHandshake, triggerPulse;
  logic returnLocal, sendEoi, secValid, secInvalid, takeCtrlAsync;
  logic takeCtrlSync, takeCtrlSyncEnd, goStandby, listenCmd, listenCont;
  logic localUnlisten, execParPoll, disableSysCtrl, parPollFlag, ifcAssert;
  logic renAssert, sysCtrlEn, acceptorHold, handshakeHeld, cmdAccepted;
  logic hiddenLoad;
  logic [4:0] auxConfigA, auxConfigB, parPollResp, auxConfigE;
  logic [3:0] clockDividerCount;
  int n_mismatch = 0;
  int cmp_count = 0;
  // pulses in the order of the code table below
  wire logic [15:0] pv = {chipResetPulse, finishHandshake, triggerPulse,
    returnLocal, sendEoi, secValid, secInvalid, takeCtrlAsync,
    takeCtrlSync, takeCtrlSyncEnd, goStandby, listenCmd, listenCont,
    localUnlisten, execParPoll, disableSysCtrl};
  wire logic [5:0] lv = {parPollFlag, ifcAssert, renAssert, sysCtrlEn,
    acceptorHold, handshakeHeld};
  localparam logic [4:0] PCODE [16] = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h06,
    5'h0F, 5'h07, 5'h11, 5'h12, 5'h1A, 5'h10, 5'h13, 5'h1B, 5'h1C, 5'h1D,
    5'h14};
  localparam logic [4:0] LCODE [6] = '{5'h09, 5'h1E, 5'h1F, 5'h01, 5'h16,
    5'h17};
  localparam logic [5:0] LEXP [6] = '{6'h20, 6'h30, 6'h38, 6'h18, 6'h08,
    6'h00};

  always #10 clk_sys = ~clk_sys;

  acd_aux_command_decoder dut_u (.clk_sys, .rst_n, .hostAddr, .hostData,
    .hostWrEn, .sysCtrlSet, .secCaptured, .holdoffSeen, .ponActive,
    .ponPulse, .chipResetPulse, .finishHandshake, .triggerPulse,
    .returnLocal, .sendEoi, .secValid, .secInvalid, .takeCtrlAsync,
    .takeCtrlSync, .takeCtrlSyncEnd, .goStandby, .listenCmd, .listenCont,
    .localUnlisten, .execParPoll, .disableSysCtrl, .parPollFlag,
    .ifcAssert, .renAssert, .sysCtrlEn, .acceptorHold, .handshakeHeld,
    .cmdAccepted, .hiddenLoad, .auxConfigA, .auxConfigB, .parPollResp,
    .auxConfigE, .clockDividerCount);
  acd_host_model host_u (.clk_sys, .hostAddr, .hostData, .hostWrEn);

  // ---------------------------------------------------------------
  // shared helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one write to the port, then release; result is visible on return
  task automatic go(input logic [7:0] d);
    host_u.wr(4'hB, d);
    host_u.idle();
  endtask
  // one-cycle event from the core: 0 sysctl, 1 capture, 2 holdoff
  task automatic core(input int k);
    @(posedge clk_sys);
    #2;
    {holdoffSeen, secCaptured, sysCtrlSet} = 3'(3'b001 << k);
    @(posedge clk_sys);
    #2;
    {holdoffSeen, secCaptured, sysCtrlSet} = 3'b000;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk(16'({ponActive, clockDividerCount}), 16'h0018);
    chk(16'({auxConfigA, auxConfigB, auxConfigE}), 16'h0000);
    chk(16'(lv), 16'h0000);
    go(8'h00);
    chk(16'({ponActive, ponPulse}), 16'h0000);
    go(8'h00);
    chk(16'({ponActive, ponPulse, cmdAccepted}), 16'h0003);
    $display("test reset done");
  endtask
  task automatic t_pulses();
    for (int i = 0; i < 16; i++) begin
      go({3'h0, PCODE[i]});
      chk(pv, 16'h8000 >> i);
      chk(16'({cmdAccepted, hiddenLoad}), 16'h0002);
    end
    go(8'h00);
    $display("test pulses done");
  endtask
  task automatic t_levels();
    for (int i = 0; i < 6; i++) begin
      go({3'h0, LCODE[i]});
      chk(16'(lv), 16'(LEXP[i]));
    end
    $display("test levels done");
  endtask
  task automatic t_hidden();
    go(8'h3A);
    go(8'h75);
    go(8'h9F);
    go(8'hA3);
    go(8'hEC);
    chk(16'({hiddenLoad, cmdAccepted}), 16'h0002);
    chk(pv, 16'h0000);
    go(8'h5F);
    go(8'hDF);
    chk(16'({parPollResp, clockDividerCount}), 16'h015A);
    chk(16'({auxConfigA, auxConfigB, auxConfigE}), 16'h7C6C);
    host_u.wr(4'hA, 8'h04);
    host_u.idle();
    chk(pv | 16'({hiddenLoad, cmdAccepted}), 16'h0000);
    go(8'h08);
    chk(pv | 16'({hiddenLoad, cmdAccepted}), 16'h0000);
    go(8'h02);
    chk(16'({auxConfigA, auxConfigB, auxConfigE}), 16'h0000);
    chk(16'({ponActive, parPollResp, clockDividerCount}), 16'h0358);
    go(8'h00);
    $display("test hidden done");
  endtask
  task automatic t_holds();
    core(1);
    chk(16'(acceptorHold), 16'h0001);
    go(8'h0F);
    chk(16'(acceptorHold), 16'h0000);
    core(1);
    go(8'h07);
    chk(16'(acceptorHold), 16'h0000);
    core(2);
    chk(16'(handshakeHeld), 16'h0001);
    go(8'h03);
    chk(16'({handshakeHeld, finishHandshake}), 16'h0001);
    core(0);
    go(8'h14);
    chk(16'(sysCtrlEn), 16'h0000);
    core(0);
    chk(16'(sysCtrlEn), 16'h0001);
    go(8'h02);
    chk(16'({sysCtrlEn, ponActive}), 16'h0001);
    go(8'h00);
    $display("test holds done");
  endtask
  task automatic t_b2b();
    host_u.wr(4'hB, 8'h04);
    host_u.wr(4'hB, 8'h05);
    chk(16'({triggerPulse, returnLocal}), 16'h0002);
    host_u.idle();
    chk(16'({triggerPulse, returnLocal}), 16'h0001);
    $display("test back to back done");
  endtask

  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // watchdog: the tests need about a hundred cycles, this allows 5000
  initial begin
    #100us;
    n_mismatch++;
    end_sim();
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    #2;
    rst_n = 1'b1;
    t_reset();
    t_pulses();
    t_levels();
    t_hidden();
    t_holds();
    t_b2b();
    end_sim();
  end
endmodule // tb_aux_command_decoder
